// *** verilog/scg_pkg.sv ***
// Purpose: Shared constants for the system clock generator control block.
// Assumes: Registers sit on a 32-bit classic Wishbone bus, one word each.
// Notes:   Byte address of a register is four times its index.
package scg_pkg;

   // Register indices and byte addresses.
   localparam logic [9:0]  SYSTEM_CLOCK_CONTROL_IDX        = 10'h08a;
   localparam logic [9:0]  LOOP_IDX        = 10'h0d9;
   localparam logic [11:0] SYSTEM_CLOCK_CONTROL_ADDR       = 12'h228;
   localparam logic [11:0] LOOP_ADDR       = 12'h364;

   // Reset values.
   localparam logic [7:0]  SYSTEM_CLOCK_CONTROL_RESET      = 8'h24;
   localparam logic [6:0]  LOOP_RESET      = 7'h00;

   // System clock control field positions.
   localparam int          SC_STOP_DEPTH   = 7;
   localparam int          SC_DIV_LO       = 5;
   localparam int          SC_SCHEME       = 4;
   localparam int          SC_RC_HALT      = 3;
   localparam int          SC_XTAL_HALT    = 2;
   localparam int          SC_SRC_LO       = 0;

   // Loop control field positions.
   localparam int          LP_STATUS       = 7;
   localparam int          LP_OUT_SEL      = 6;
   localparam int          LP_VDC_SUB      = 5;
   localparam int          LP_FB_LO        = 3;
   localparam int          LP_POST_DIV_LO  = 1;
   localparam int          LP_ENABLE       = 0;

   // Clock source codes.
   localparam logic [1:0]  SRC_RC          = 2'h0;
   localparam logic [1:0]  SRC_XTAL        = 2'h1;
   localparam logic [1:0]  SRC_SUB_LOOP    = 2'h2;
   localparam logic [1:0]  SRC_RING        = 2'h3;

   // Power control values; only the stop value enables the stop depth choice.
   localparam logic [7:0]  POWER_CONTROL_REG_STOP       = 8'h03;
   localparam logic [7:0]  POWER_CONTROL_REG_IDLE       = 8'h01;

   // Sub oscillator periods needed to finish a loop disable.
   localparam logic [1:0]  LOOP_OFF_PERIODS = 2'h2;

   typedef enum logic [1:0] {
      SW_RUN,
      SW_DRAIN,
      SW_ALIGN
   } scg_sw_e;

endpackage

// *** verilog/scg_ctrl.sv ***
// Purpose: System clock source selection, prescaling and oscillator control.
// Assumes: Oscillator levels arrive as inputs sampled on i_mclk, which must
//          run well above the fastest source.
// Notes:   The system clock is rebuilt from sampled levels, so it carries
//          sampling jitter of one i_mclk period.
//
// Behaviour
// - Reset runs internal RC divided by two.
// - Timer clock from 1 MHz ring, always.
// - Stop depth bit applies at power control 0x03.
// - Prescale divides RC by 1, 2, 4, 8.
// - Scheme 0: source change waits for wake.
// - Scheme 1: source change applies at once.
// - RC halt bit acts only under scheme 1.
// - Crystal halt resets to 1, scheme 1 only.
// - Fuse 0 forces crystal halt to 1.
// - Source codes: RC, crystal, sub/loop, ring.
// - Loop status shows bypass or loop output.
// - Output select picks bypass or loop output.
// - Interrupt in low power sets output select.
// - Loop disable completes after two sub periods.
// - Post divide by 1, 2, 4, 8.
//
// The Wishbone slave port was chosen for this implementation.
`timescale 1ns/100ps

module scg_ctrl (
   input  wire logic        i_mclk,             // Block clock, 25 MHz
   input  wire logic        i_rstn,             // Asynchronous reset, low
   input  wire logic        i_ce,               // Clock enable, freezes all
   input  wire logic        i_wb_cyc,           // Wishbone cycle
   input  wire logic        i_wb_stb,           // Wishbone strobe
   input  wire logic        i_wb_we,            // Wishbone write enable
   input  wire logic [11:0] i_wb_adr,           // Wishbone byte address
   input  wire logic [3:0]  i_wb_sel,           // Wishbone byte selects
   input  wire logic [31:0] i_wb_dat,           // Wishbone write data
   output logic             o_wb_ack,           // Wishbone acknowledge
   output logic [31:0]      o_wb_dat,           // Wishbone read data
   input  wire logic        i_rc_osc,           // Internal RC level
   input  wire logic        i_xtal_osc,         // Main crystal level
   input  wire logic        i_sub_osc,          // Sub crystal level
   input  wire logic        i_loop_osc,         // Loop oscillator level
   input  wire logic        i_ring_osc,         // 125 kHz ring level
   input  wire logic        i_ring_1m,          // 1 MHz ring level
   input  wire logic        i_crystal_input_fuse, // Crystal input option
   input  wire logic [7:0]  i_power_control,    // Power control value
   input  wire logic        i_stop_wake,        // Wake from stop, pulse
   input  wire logic        i_low_power_irq,    // Irq in low power, pulse
   output logic             o_sys_clk,          // System clock
   output logic [1:0]       o_sys_src,          // Source now in use
   output logic             o_timer_clk,        // Timer/watchdog clock
   output logic             o_rc_osc_run,       // Internal RC enable
   output logic             o_xtal_osc_run,     // Main crystal enable
   output logic             o_loop_run,         // Loop enable
   output logic [1:0]       o_loop_fb,          // Loop feedback divider
   output logic             o_vdc_on_sub,       // Regulator choice
   output logic             o_deep_stop,        // Deep stop selected
   output logic             o_shallow_stop      // Shallow stop selected
);

   typedef struct packed {
      logic [7:0]     system_clock_control;
      logic [6:0]     loop;
      logic           loop_status;
      logic [1:0]     src_act;
      logic [1:0]     div_act;
      logic [1:0]     src_nxt;
      logic [1:0]     div_nxt;
      scg_pkg::scg_sw_e sw;
      logic [2:0]     rc_cnt;
      logic [2:0]     loop_cnt;
      logic           rc_prev;
      logic           loop_prev;
      logic           sub_prev;
      logic [1:0]     off_cnt;
      logic           loop_run;
      logic           rc_run;
      logic           xtal_run;
      logic           sys_clk;
      logic           timer_clk;
      logic           deep;
      logic           shallow;
      logic           ack;
      logic [7:0]     rdat;
   } scg_state_s;

   scg_state_s s_q;
   scg_state_s s_d;

   // Divided level of a free-running ripple count, picked by a 2-bit code.
   function automatic logic div_level(input logic       lvl,
                                      input logic [2:0] cnt,
                                      input logic [1:0] code);
      unique case (code)
         2'h0:    div_level = lvl;
         2'h1:    div_level = cnt[0];
         2'h2:    div_level = cnt[1];
         2'h3:    div_level = cnt[2];
      endcase
   endfunction

   logic       bus_req;
   logic       wr_system_clock_control;
   logic       wr_loop;
   logic [1:0] src_tgt;
   logic [1:0] div_tgt;
   logic       loop_out;
   logic       cur_lvl;
   logic       new_lvl;

   // Source level seen for a given source and prescale code.
   function automatic logic src_level(input logic [1:0] src,
                                      input logic [1:0] dv,
                                      input logic [2:0] rcc,
                                      input logic       rcl,
                                      input logic       xl,
                                      input logic       ll,
                                      input logic       rgl);
      unique case (src)
         scg_pkg::SRC_RC:       src_level = div_level(rcl, rcc, dv);
         scg_pkg::SRC_XTAL:     src_level = xl;
         scg_pkg::SRC_SUB_LOOP: src_level = ll;
         scg_pkg::SRC_RING:     src_level = rgl;
      endcase
   endfunction

   always_comb begin
      s_d = s_q;
      bus_req = i_wb_cyc & i_wb_stb & ~s_q.ack;
      wr_system_clock_control = bus_req & i_wb_we & i_wb_sel[0]
                & (i_wb_adr[11:2] == scg_pkg::SYSTEM_CLOCK_CONTROL_IDX);
      wr_loop = bus_req & i_wb_we & i_wb_sel[0]
                & (i_wb_adr[11:2] == scg_pkg::LOOP_IDX);

      // Ack one cycle after the request; unmapped reads return zero.
      s_d.ack = bus_req;
      if (bus_req) begin
         if (i_wb_adr[11:2] == scg_pkg::SYSTEM_CLOCK_CONTROL_IDX) begin
            s_d.rdat = s_q.system_clock_control;
         end else if (i_wb_adr[11:2] == scg_pkg::LOOP_IDX) begin
            s_d.rdat = {s_q.loop_status, s_q.loop};
         end else begin
            s_d.rdat = 8'h00;
         end
      end

      if (wr_system_clock_control) begin
         s_d.system_clock_control = i_wb_dat[7:0];
      end
      if (!i_crystal_input_fuse) begin
         s_d.system_clock_control[scg_pkg::SC_XTAL_HALT] = 1'b1;
      end

      if (wr_loop) begin
         s_d.loop = i_wb_dat[6:0];
      end
      if (i_low_power_irq) begin
         s_d.loop[scg_pkg::LP_OUT_SEL] = 1'b1;
      end

      // Crystal halt gated
      // Run enables are kept high-true so the outputs leave a flop
      // directly; under scheme 0 RC keeps its last value, and crystal does too unless fuse 0 clears it.
      if (s_q.system_clock_control[scg_pkg::SC_SCHEME]) begin
         s_d.rc_run   = ~s_q.system_clock_control[scg_pkg::SC_RC_HALT];
         s_d.xtal_run = ~s_q.system_clock_control[scg_pkg::SC_XTAL_HALT];
      end
      if (!i_crystal_input_fuse) begin
         s_d.xtal_run = 1'b0;
      end

      // Ripple counts on rising edges of RC and loop oscillators.
      s_d.rc_prev   = i_rc_osc;
      s_d.loop_prev = i_loop_osc;
      s_d.sub_prev  = i_sub_osc;
      if (i_rc_osc & ~s_q.rc_prev) begin
         s_d.rc_cnt = s_q.rc_cnt + 3'h1;
      end
      if (i_loop_osc & ~s_q.loop_prev) begin
         s_d.loop_cnt = s_q.loop_cnt + 3'h1;
      end

      if (s_q.loop[scg_pkg::LP_ENABLE]) begin
         s_d.loop_run = 1'b1;
         s_d.off_cnt  = 2'h0;
      end else if (s_q.loop_run && i_sub_osc && !s_q.sub_prev) begin
         if (s_q.off_cnt == scg_pkg::LOOP_OFF_PERIODS - 2'h1) begin
            s_d.loop_run = 1'b0;
            s_d.off_cnt  = 2'h0;
         end else begin
            s_d.off_cnt = s_q.off_cnt + 2'h1;
         end
      end

      loop_out = (s_q.loop[scg_pkg::LP_OUT_SEL] && s_q.loop_run)
                 ? div_level(i_loop_osc, s_q.loop_cnt,
                             s_q.loop[scg_pkg::LP_POST_DIV_LO +: 2])
                 : i_sub_osc;
      // Status lags the select by one cycle, as it is read from flops.
      s_d.loop_status = s_q.loop[scg_pkg::LP_OUT_SEL] & s_q.loop_run;

      // Immediate under scheme 1
      // Scheme 0 sees the register only in the wake cycle; a write at
      // any other time waits in the register until the next wake.
      src_tgt = s_q.src_act;
      div_tgt = s_q.div_act;
      if (s_q.system_clock_control[scg_pkg::SC_SCHEME] || i_stop_wake) begin
         src_tgt = s_q.system_clock_control[scg_pkg::SC_SRC_LO +: 2];
         div_tgt = s_q.system_clock_control[scg_pkg::SC_DIV_LO +: 2];
      end

      cur_lvl = src_level(s_q.src_act, s_q.div_act, s_q.rc_cnt, i_rc_osc,
                          i_xtal_osc, loop_out, i_ring_osc);
      // Level of the latched target; it decides when the clock rejoins.
      new_lvl = src_level(s_q.src_nxt, s_q.div_nxt, s_q.rc_cnt, i_rc_osc,
                          i_xtal_osc, loop_out, i_ring_osc);

      // Switch only between two low phases
      unique case (s_q.sw)
         scg_pkg::SW_RUN: begin
            s_d.sys_clk = cur_lvl;
            if (src_tgt != s_q.src_act || div_tgt != s_q.div_act) begin
               // Latch the target: under scheme 0 it is visible only in
               // the wake cycle and would be lost before the drain ends.
               s_d.src_nxt = src_tgt;
               s_d.div_nxt = div_tgt;
               s_d.sw      = scg_pkg::SW_DRAIN;
            end
         end
         scg_pkg::SW_DRAIN: begin
            // Finish the old high phase before parking low.
            s_d.sys_clk = cur_lvl;
            if (!cur_lvl) begin
               s_d.sys_clk = 1'b0;
               s_d.src_act = s_q.src_nxt;
               s_d.div_act = s_q.div_nxt;
               s_d.sw      = scg_pkg::SW_ALIGN;
            end
         end
         scg_pkg::SW_ALIGN: begin
            // Rejoin only on a low level so the next high phase is whole.
            s_d.sys_clk = 1'b0;
            if (!new_lvl) begin
               s_d.sw = scg_pkg::SW_RUN;
            end
         end
         default: begin
            s_d.sw = scg_pkg::SW_RUN;
         end
      endcase

      s_d.timer_clk = i_ring_1m;

      s_d.deep    = (i_power_control == scg_pkg::POWER_CONTROL_REG_STOP)
                    & s_q.system_clock_control[scg_pkg::SC_STOP_DEPTH];
      s_d.shallow = (i_power_control == scg_pkg::POWER_CONTROL_REG_STOP)
                    & ~s_q.system_clock_control[scg_pkg::SC_STOP_DEPTH];
   end

   // Reset to RC divided by two
   always_ff @(posedge i_mclk or negedge i_rstn) begin
      if (!i_rstn) begin
         s_q               <= '0;
         s_q.system_clock_control          <= scg_pkg::SYSTEM_CLOCK_CONTROL_RESET;
         s_q.loop          <= scg_pkg::LOOP_RESET;
         s_q.src_act       <= scg_pkg::SRC_RC;
         s_q.div_act       <= scg_pkg::SYSTEM_CLOCK_CONTROL_RESET[scg_pkg::SC_DIV_LO +: 2];
         s_q.sw            <= scg_pkg::SW_RUN;
         s_q.rc_run        <= 1'b1;
      end else if (i_ce) begin
         s_q <= s_d;
      end
   end

   assign o_wb_ack       = s_q.ack;
   assign o_wb_dat       = {24'h000000, s_q.rdat};
   assign o_sys_clk      = s_q.sys_clk;
   assign o_sys_src      = s_q.src_act;
   assign o_timer_clk    = s_q.timer_clk;
   assign o_rc_osc_run   = s_q.rc_run;
   assign o_xtal_osc_run = s_q.xtal_run;
   assign o_loop_run     = s_q.loop_run;
   assign o_loop_fb      = s_q.loop[scg_pkg::LP_FB_LO +: 2];
   assign o_vdc_on_sub   = s_q.loop[scg_pkg::LP_VDC_SUB];
   assign o_deep_stop    = s_q.deep;
   assign o_shallow_stop = s_q.shallow;

endmodule // scg_ctrl

// *** testbench/scg_ctrl_props.sv ***
// Purpose: Port-level timing checks for the clock control block.
// Assumes: Bound to every instance of the clock control block.
// Notes:   One clock domain, so default clocking and disable are used.
`timescale 1ns/100ps
module scg_ctrl_props (
   input wire logic        i_mclk,               // Block clock
   input wire logic        i_rstn,               // Reset, low
   input wire logic        i_ce,                 // Clock enable
   input wire logic        i_wb_cyc,             // Bus cycle
   input wire logic        i_wb_stb,             // Bus strobe
   input wire logic        o_wb_ack,             // Bus acknowledge
   input wire logic [31:0] o_wb_dat,             // Bus read data
   input wire logic        i_ring_1m,            // 1 MHz ring level
   input wire logic        o_timer_clk,          // Timer clock
   input wire logic [7:0]  i_power_control,      // Power control
   input wire logic        o_deep_stop,          // Deep stop
   input wire logic        o_shallow_stop,       // Shallow stop
   input wire logic        i_crystal_input_fuse, // Crystal fuse
   input wire logic        o_xtal_osc_run,       // Crystal enable
   input wire logic        o_rc_osc_run,         // RC enable
   input wire logic [1:0]  o_sys_src             // Source in use
);
   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (!i_rstn);

   property p_ack_next;
      i_wb_cyc && i_wb_stb && !o_wb_ack && i_ce |=> o_wb_ack;
   endproperty
   a_ack_next: assert property (p_ack_next) else $error("ack not next");

   property p_ack_pulse;
      o_wb_ack |=> !o_wb_ack;
   endproperty
   a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");

   property p_dat_hi;
      o_wb_ack |-> o_wb_dat[31:8] == 24'h0;
   endproperty
   a_dat_hi: assert property (p_dat_hi) else $error("upper data set");

   property p_timer;
      i_ce && i_rstn |=> o_timer_clk == $past(i_ring_1m);
   endproperty
   a_timer: assert property (p_timer) else $error("timer clk");

   property p_stop_off;
      i_ce && i_power_control != 8'h03 |=> !o_deep_stop && !o_shallow_stop;
   endproperty
   a_stop_off: assert property (p_stop_off) else $error("stop on");

   property p_stop_one;
      i_ce && i_rstn && i_power_control == 8'h03
         |=> o_deep_stop ^ o_shallow_stop;
   endproperty
   a_stop_one: assert property (p_stop_one) else $error("stop pick");

   property p_fuse;
      !i_crystal_input_fuse [*4] |-> !o_xtal_osc_run;
   endproperty
   a_fuse: assert property (p_fuse) else $error("crystal on");

   property p_rst_src;
      $rose(i_rstn) |-> o_sys_src == 2'h0;
   endproperty
   a_rst_src: assert property (p_rst_src) else $error("reset src");

   property p_rst_osc;
      $rose(i_rstn) |-> o_rc_osc_run && !o_xtal_osc_run;
   endproperty
   a_rst_osc: assert property (p_rst_osc) else $error("reset osc");
endmodule // scg_ctrl_props

bind scg_ctrl scg_ctrl_props u_props (.i_mclk, .i_rstn, .i_ce, .i_wb_cyc,
   .i_wb_stb, .o_wb_ack, .o_wb_dat, .i_ring_1m, .o_timer_clk,
   .i_power_control, .o_deep_stop, .o_shallow_stop, .i_crystal_input_fuse,
   .o_xtal_osc_run, .o_rc_osc_run, .o_sys_src);

// *** testbench/scg_ctrl_tb_top.sv ***
// Purpose: Self-checking bench for the system clock control block.
// Assumes: Oscillators are square waves several block clocks long.
// Notes:   Reads are scored through a queue; levels are checked directly.
`timescale 1ns/100ps
module scg_ctrl_tb_top;
   logic        i_mclk, i_rstn, i_ce, i_wb_cyc, i_wb_stb, i_wb_we, o_wb_ack;
   logic [11:0] i_wb_adr;
   logic [3:0]  i_wb_sel;
   logic [31:0] i_wb_dat, o_wb_dat;
   logic        i_rc_osc, i_xtal_osc, i_sub_osc, i_loop_osc, i_ring_osc;
   logic        i_ring_1m, i_crystal_input_fuse, i_stop_wake;
   logic [7:0]  i_power_control;
   logic        i_low_power_irq, o_sys_clk, o_timer_clk, o_rc_osc_run;
   logic [1:0]  o_sys_src, o_loop_fb;
   logic        o_xtal_osc_run, o_loop_run, o_vdc_on_sub;
   logic        o_deep_stop, o_shallow_stop;
   int          err_count, compares, seed, n, t;
   logic [32:0] exp_q[$];
   logic [32:0] e;
   localparam logic [11:0] SC = scg_pkg::SYSTEM_CLOCK_CONTROL_ADDR;
   localparam logic [11:0] LP = scg_pkg::LOOP_ADDR;

   scg_ctrl u_scg_ctrl (.i_mclk, .i_rstn, .i_ce, .i_wb_cyc, .i_wb_stb,
      .i_wb_we, .i_wb_adr, .i_wb_sel, .i_wb_dat, .o_wb_ack, .o_wb_dat,
      .i_rc_osc, .i_xtal_osc, .i_sub_osc, .i_loop_osc, .i_ring_osc,
      .i_ring_1m, .i_crystal_input_fuse, .i_power_control, .i_stop_wake,
      .i_low_power_irq, .o_sys_clk, .o_sys_src, .o_timer_clk, .o_rc_osc_run,
      .o_xtal_osc_run, .o_loop_run, .o_loop_fb, .o_vdc_on_sub,
      .o_deep_stop, .o_shallow_stop);

   initial begin
      i_mclk = 1'b0;
      forever #20 i_mclk = ~i_mclk;
   end

   // Periods in block clocks: RC 4, crystal 6, sub 10, ring 14.
   always @(posedge i_mclk) begin
      t <= t + 1;
      i_rc_osc <= (t % 4) < 2;
      i_xtal_osc <= (t % 6) < 3;
      i_sub_osc <= (t % 10) < 5;
      i_loop_osc <= (t % 8) < 4;
      i_ring_osc <= (t % 14) < 7;
      i_ring_1m <= t[0];
   end

   task automatic final_report;
      if (err_count == 0 && compares > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] x,
                      input logic [31:0] g);
      compares++;
      if (g !== x) begin
         err_count++;
         $display("CHECK FAILED %s expected %h seen %h", nm, x, g);
      end
   endtask

   always @(posedge i_mclk) begin
      if (o_wb_ack === 1'b1) begin
         e = exp_q.pop_front();
         if (e[32] === 1'b1) chk("read data", e[31:0], o_wb_dat);
      end
   end

   task automatic bus(input logic w, input logic [11:0] a,
                      input logic [7:0] d, input logic [7:0] x);
      exp_q.push_back({!w, 24'h0, x});
      i_wb_cyc <= 1'b1;
      i_wb_stb <= 1'b1;
      i_wb_we <= w;
      i_wb_adr <= a;
      i_wb_dat <= {24'h0, d};
      do @(posedge i_mclk); while (o_wb_ack !== 1'b1);
      i_wb_cyc <= 1'b0;
      i_wb_stb <= 1'b0;
      @(posedge i_mclk);
   endtask

   task automatic period(input int p);
      time t0;
      repeat (60) @(posedge i_mclk);
      @(posedge o_sys_clk);
      t0 = $time;
      @(posedge o_sys_clk);
      chk("clock period", 32'(p), 32'(($time - t0) / 40));
   endtask

   task automatic stopchk(input logic [7:0] pc, input logic deep);
      i_power_control <= pc;
      repeat (3) @(posedge i_mclk);
      chk("deep stop", 32'(pc == 8'h03 && deep), 32'(o_deep_stop));
      chk("shallow", 32'(pc == 8'h03 && !deep), 32'(o_shallow_stop));
   endtask

   initial begin
      #(40 * 20000);
      err_count++;
      final_report();
   end

   initial begin
      {i_wb_cyc, i_wb_stb, i_wb_we, i_stop_wake, i_low_power_irq} = 5'h0;
      {i_wb_adr, i_wb_dat, i_power_control} = '0;
      {i_ce, i_crystal_input_fuse, i_wb_sel, seed} = {2'h3, 4'hf, 32'd76229};
      i_rstn = 1'b0;
      repeat (3) @(posedge i_mclk);
      i_rstn <= 1'b1;
      @(posedge i_mclk);
      bus(0, SC, 8'h00, 8'h24);
      bus(0, LP, 8'h00, 8'h00);
      bus(0, 12'h000, 8'h00, 8'h00);
      period(8);
      bus(1, SC, 8'h27, 8'h00);
      repeat (20) @(posedge i_mclk);
      chk("pending source", 32'h0, 32'(o_sys_src));
      i_stop_wake <= 1'b1;
      @(posedge i_mclk);
      i_stop_wake <= 1'b0;
      period(14);
      bus(1, SC, 8'h37, 8'h00);
      for (n = 0; n < 4; n++) begin
         bus(1, SC, 8'(8'h10 + n * 32), 8'h00);
         period(4 << n);
      end
      for (n = 1; n < 4; n++) begin
         bus(1, SC, 8'(8'h10 + n), 8'h00);
         period(2 + 4 * n);
         chk("source", 32'(n), 32'(o_sys_src));
      end
      chk("crystal run", 32'h1, 32'(o_xtal_osc_run));
      bus(1, SC, 8'h1b, 8'h00);
      i_crystal_input_fuse <= 1'b0;
      repeat (5) @(posedge i_mclk);
      chk("rc run", 32'h0, 32'(o_rc_osc_run));
      chk("fused crystal", 32'h0, 32'(o_xtal_osc_run));
      bus(0, SC, 8'h00, 8'h1f);
      i_crystal_input_fuse <= 1'b1;
      bus(1, SC, 8'h0f, 8'h00);
      bus(1, SC, 8'h03, 8'h00);
      repeat (4) @(posedge i_mclk);
      chk("frozen rc", 32'h0, 32'(o_rc_osc_run));
      bus(1, SC, 8'h93, 8'h00);
      stopchk(8'h03, 1'b1);
      for (n = 0; n < 4; n++) begin
         // Bit 1 kept set: the stop depth bit is on, so 0x01 is barred.
         stopchk(8'($random(seed)) | 8'h02, 1'b1);
      end
      bus(1, SC, 8'h13, 8'h00);
      stopchk(8'h03, 1'b0);
      bus(1, LP, 8'hc1, 8'h00);
      bus(0, LP, 8'h00, 8'hc1);
      bus(1, LP, 8'h40, 8'h00);
      chk("loop run held", 32'h1, 32'(o_loop_run));
      repeat (30) @(posedge i_mclk);
      chk("loop run off", 32'h0, 32'(o_loop_run));
      bus(0, LP, 8'h00, 8'h40);
      bus(1, LP, 8'h01, 8'h00);
      i_low_power_irq <= 1'b1;
      @(posedge i_mclk);
      i_low_power_irq <= 1'b0;
      // Status follows the select one cycle later.
      @(posedge i_mclk);
      bus(0, LP, 8'h00, 8'hc1);
      bus(1, SC, 8'h12, 8'h00);
      for (n = 0; n < 4; n++) begin
         bus(1, LP, 8'(8'h41 + n * 2), 8'h00);
         period(8 << n);
      end
      for (n = 0; n < 4; n++) begin
         bus(1, LP, 8'(n * 10 + n % 2 * 32), 8'h00);
         bus(0, LP, 8'h00, 8'(n * 10 + n % 2 * 32));
         chk("feedback", 32'(n), 32'(o_loop_fb));
         chk("regulator", 32'(n % 2), 32'(o_vdc_on_sub));
      end
      final_report();
   end
endmodule // scg_ctrl_tb_top
